/* rtl/mmc_pkg.sv */
/*
  Constants, register map and carrier types of the memory map and
  configuration block.
  Assumes a 16-bit CPU address space and APB with 32-bit data.
*/
package mmc_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SETUP     = 8'h00;
  localparam logic [7:0] OFS_PLACEMENT = 8'h04;
  localparam logic [7:0] OFS_CHOICES   = 8'h08;
  localparam logic [7:0] OFS_PROM_CTRL = 8'h0c;
  localparam logic [7:0] OFS_STATUS    = 8'h10;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_SETUP     = 8'hff;
  localparam logic [7:0] RST_PLACEMENT = 8'h01;
  localparam logic [7:0] RST_CHOICES   = 8'h10;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SEC_DIS_BIT  = 3;
  localparam int WDOG_OFF_BIT = 2;
  localparam int ROM_EN_BIT   = 1;
  localparam int NVM_PRES_BIT = 0;
  localparam int CONV_PU_BIT  = 7;
  localparam int PUMP_SEL_BIT = 6;
  localparam int IRQ_EDGE_BIT = 5;
  localparam int OSC_WAIT_BIT = 4;
  localparam int CLK_MON_BIT  = 3;
  localparam int LATCH_BIT    = 5;
  localparam int VPP_BIT      = 0;
  // Time-protected option bits and always-zero bit
  localparam logic [7:0] CHOICES_PROT = 8'h33;
  localparam logic [7:0] CHOICES_IMPL = 8'hfb;
  // ----------------------------------------------------------------
  // Cycle counts at the E clock (pclk, 100 MHz)
  // ----------------------------------------------------------------
  localparam logic [11:0] WRITE_WINDOW_CYC = 12'd64;
  localparam logic [11:0] OSC_SETTLE_CYC   = 12'd4000;
  localparam logic [11:0] FAST_WAKE_CYC    = 12'd4;
  localparam int          WDOG_PRE_BITS    = 15;
  // ----------------------------------------------------------------
  // Memory map default ROM base
  // ----------------------------------------------------------------
  localparam logic [15:0] ROM_BASE_DFLT = 16'hd000;
  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic regs;
    logic ram;
    logic nvm;
    logic rom;
    logic ext;
  } mmc_map_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } mmc_prom_type;
endpackage : mmc_pkg

/* rtl/mmc_countdown.sv */
/*
  Down counter that is busy while nonzero.
  Assumes load is a single-cycle request.
*/
`timescale 1ns/1ps
`default_nettype none
module mmc_countdown #(
  parameter logic [11:0] RST_VAL = 12'd0
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        load,
  input  wire logic [11:0] value,
  output var  logic        busy
);
  logic [11:0] cnt_ff;
  logic [11:0] nxt_cnt;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (load) begin
      nxt_cnt = value;
    end else if (cnt_ff != 12'h000) begin
      nxt_cnt = cnt_ff - 12'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= RST_VAL;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign busy = (cnt_ff != 12'h000);
endmodule // mmc_countdown
`default_nettype wire

/* rtl/mmc_wdog_div.sv */
/*
  Watchdog clock: E clock divided by 2^15, then by 1, 4, 16 or 64.
  Assumes enable low holds the divider cleared.
*/
`timescale 1ns/1ps
`default_nettype none
module mmc_wdog_div
  import mmc_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       enable,
  input  wire logic [1:0] rate_sel,
  output var  logic       tick
);
  logic [WDOG_PRE_BITS-1:0] pre_ff;
  logic [WDOG_PRE_BITS-1:0] nxt_pre;
  logic [5:0]               rate_ff;
  logic [5:0]               nxt_rate;
  logic [5:0]               rate_mask;
  logic                     pre_wrap;

  always_comb begin
    rate_mask = 6'(~(6'h3f << {rate_sel, 1'b0}));
    pre_wrap  = &pre_ff;
    nxt_pre   = enable ? pre_ff + 1'b1 : '0;
    nxt_rate  = rate_ff;
    tick      = 1'b0;
    if (!enable) begin
      nxt_rate = 6'h00;
    end else if (pre_wrap) begin
      tick     = ((rate_ff & rate_mask) == rate_mask);
      nxt_rate = tick ? 6'h00 : rate_ff + 6'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff  <= '0;
      rate_ff <= 6'h00;
    end else begin
      pre_ff  <= nxt_pre;
      rate_ff <= nxt_rate;
    end
  end
endmodule // mmc_wdog_div
`default_nettype wire

/* rtl/mmc_top.sv */
/*
  Memory map configuration, time-protected options and PROM byte
  programming control, reached over APB.
  Assumes the CPU bus and mode straps are synchronous to pclk and
  pclk is the E clock.
*/
// Our own choices: the address map and the APB slave port.
// How it works
// R1: NVM at n800-nFFF for window value n
// R2: Security bit 0 secures; reads 1 without option (here the bit is only stored and read back, no logic acts on it)
// R3: Watchdog-off bit 1 stops the watchdog
// R4: ROM enable 0 sends ROM range external
// R5: Single-chip mode forces ROM enable on
// R6: NVM present 0 sends NVM range external
// R7: Placement written once, first 64 cycles; special anytime
// R8: RAM page digit sets RAM base, reset zero
// R9: Register page digit sets 64-byte block, reset one
// R10: Protected options once in 64 cycles; special anytime
// R11: Wait disabled resumes within four cycles
// R12: Wait enabled holds about 4000 cycles
// R13: Watchdog clock is E over 2^15, scaled
// R14: Pump select also picks converter clock
// R15: Pump select 0 E clock, 1 RC
// R16: Programming only clears ones to zeros
// R17: Host latches then writes data byte
// R18: Host enables voltage, waits, clears control
// R19: Latch on captures writes, blocks PROM reads
// R20: Voltage needs latch; latch frozen under voltage
// R21: Decode priority registers, RAM, NVM, ROM
`timescale 1ns/1ps
`default_nettype none
module mmc_top #(
  parameter bit          SECURITY_OPT = 1'b0,
  parameter logic [15:0] ROM_BASE     = mmc_pkg::ROM_BASE_DFLT
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output var  logic [31:0]          prdata,
  output var  logic                 pready,
  output var  logic                 pslverr,
  input  wire logic                 special_mode,
  input  wire logic                 single_chip,
  input  wire logic                 cpu_valid,
  input  wire logic                 cpu_write,
  input  wire logic [15:0]          cpu_addr,
  input  wire logic [7:0]           cpu_wdata,
  input  wire logic [7:0]           prom_cell_rdata,
  input  wire logic                 stop_wake,
  output var  mmc_pkg::mmc_map_type map_sel,
  output var  logic                 prom_read_block,
  output var  mmc_pkg::mmc_prom_type prom_latch,
  output var  logic                 prom_vpp,
  output var  logic                 cpu_hold,
  output var  logic                 wdog_tick,
  output var  logic                 wdog_enabled,
  output var  logic                 pump_rc_sel,
  output var  logic                 conv_rc_sel,
  output var  logic                 conv_power_up,
  output var  logic                 irq_edge_only,
  output var  logic                 clk_monitor_en
);
  import mmc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]   setup_ff,     nxt_setup;
  logic [7:0]   place_ff,     nxt_place;
  logic [7:0]   choices_ff,   nxt_choices;
  logic         place_wr_ff,  nxt_place_wr;
  logic         opt_wr_ff,    nxt_opt_wr;
  logic         latch_ff,     nxt_latch;
  logic         vpp_ff,       nxt_vpp;
  mmc_prom_type prom_ff,      nxt_prom;
  logic [31:0]  prdata_ff,    nxt_prdata;
  logic         pready_ff,    nxt_pready;
  logic         pslverr_ff,   nxt_pslverr;
  mmc_map_type  map_ff,       nxt_map;
  logic         rd_block_ff,  nxt_rd_block;
  logic         hold_ff,      nxt_hold;
  logic         tick_ff;
  logic [7:0]   misc_ff,      nxt_misc;

  logic        window_busy;
  logic        wake_busy;
  logic        wake_load;
  logic [11:0] wake_value;
  logic        tick_raw;
  logic        setup_ph;
  logic        wr_en;
  logic        mapped;
  logic [7:0]  rd_byte;
  logic [7:0]  wb;
  logic [7:0]  setup_rd;
  logic        rom_on;
  logic        hit_regs, hit_ram, hit_nvm, hit_rom;

  // ----------------------------------------------------------------
  // Write window and stop-exit delay
  // ----------------------------------------------------------------
  mmc_countdown #(.RST_VAL(WRITE_WINDOW_CYC)) u_window (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (1'b0),
    .value   (12'h000),
    .busy    (window_busy)
  );

  assign wake_load  = stop_wake;
  assign wake_value = choices_ff[OSC_WAIT_BIT] ? OSC_SETTLE_CYC  // R12
                                               : FAST_WAKE_CYC;  // R11

  mmc_countdown #(.RST_VAL(12'h000)) u_wake (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (wake_load),
    .value   (wake_value),
    .busy    (wake_busy)
  );

  // ----------------------------------------------------------------
  // Watchdog divider
  // ----------------------------------------------------------------
  mmc_wdog_div u_wdog (
    .pclk     (pclk),
    .presetn  (presetn),
    .enable   (!setup_ff[WDOG_OFF_BIT]),  // R3
    .rate_sel (choices_ff[1:0]),          // R13
    .tick     (tick_raw)
  );

  // ----------------------------------------------------------------
  // APB register access
  // ----------------------------------------------------------------
  assign setup_ph = psel && !penable;
  assign wr_en    = psel && penable && pready_ff && pwrite && !pslverr_ff;
  assign wb       = pwdata[7:0];

  always_comb begin
    setup_rd = setup_ff;
    if (!SECURITY_OPT) begin
      setup_rd[SEC_DIS_BIT] = 1'b1;  // R2
    end
    mapped  = 1'b1;
    rd_byte = 8'h00;
    case (paddr)
      OFS_SETUP:     rd_byte = setup_rd;
      OFS_PLACEMENT: rd_byte = place_ff;
      OFS_CHOICES:   rd_byte = choices_ff & CHOICES_IMPL;
      OFS_PROM_CTRL: rd_byte = {2'b00, latch_ff, 4'h0, vpp_ff};
      OFS_STATUS:    rd_byte = {3'b000, hold_ff, wake_busy, window_busy,
                                opt_wr_ff, place_wr_ff};
      default:       mapped = 1'b0;
    endcase
    nxt_pready  = setup_ph;
    nxt_prdata  = setup_ph ? {24'h000000, rd_byte} : prdata_ff;
    nxt_pslverr = setup_ph ? !mapped : 1'b0;
  end

  always_comb begin
    nxt_setup    = setup_ff;
    nxt_place    = place_ff;
    nxt_choices  = choices_ff;
    nxt_place_wr = place_wr_ff;
    nxt_opt_wr   = opt_wr_ff;
    nxt_latch    = latch_ff;
    nxt_vpp      = vpp_ff;
    if (wr_en) begin
      case (paddr)
        OFS_SETUP: begin
          nxt_setup = wb;
        end
        OFS_PLACEMENT: begin
          if (special_mode || (window_busy && !place_wr_ff)) begin  // R7
            nxt_place    = wb;
            nxt_place_wr = 1'b1;
          end
        end
        OFS_CHOICES: begin
          if (special_mode || (window_busy && !opt_wr_ff)) begin  // R10
            nxt_choices = wb & CHOICES_IMPL;
            nxt_opt_wr  = 1'b1;
          end else begin
            nxt_choices = (choices_ff & CHOICES_PROT)
                        | (wb & CHOICES_IMPL & ~CHOICES_PROT);
          end
        end
        OFS_PROM_CTRL: begin
          if (!vpp_ff) begin
            nxt_latch = wb[LATCH_BIT];  // R20
          end
          nxt_vpp = wb[VPP_BIT] && latch_ff;  // R20
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // CPU address decode
  // ----------------------------------------------------------------
  always_comb begin
    rom_on   = setup_ff[ROM_EN_BIT] || single_chip;  // R5
    hit_regs = (cpu_addr[15:12] == place_ff[3:0])
            && (cpu_addr[11:6] == 6'h00);            // R9
    hit_ram  = (cpu_addr[15:12] == place_ff[7:4])
            && (cpu_addr[11:8] == 4'h0);             // R8
    hit_nvm  = setup_ff[NVM_PRES_BIT]                // R6
            && (cpu_addr[15:12] == setup_ff[7:4])
            && cpu_addr[11];                         // R1
    hit_rom  = rom_on && (cpu_addr >= ROM_BASE);     // R4
    nxt_map  = '0;
    if (cpu_valid) begin
      if (hit_regs) begin                            // R21
        nxt_map.regs = 1'b1;
      end else if (hit_ram) begin
        nxt_map.ram = 1'b1;
      end else if (hit_nvm) begin
        nxt_map.nvm = 1'b1;
      end else if (hit_rom) begin
        nxt_map.rom = 1'b1;
      end else begin
        nxt_map.ext = 1'b1;
      end
    end
    nxt_rd_block = latch_ff;  // R19
    nxt_prom     = prom_ff;
    if (cpu_valid && cpu_write && latch_ff && !vpp_ff && hit_rom
        && !hit_regs && !hit_ram && !hit_nvm) begin
      nxt_prom.addr = cpu_addr;                      // R19
      nxt_prom.data = cpu_wdata & prom_cell_rdata;   // R16
    end
    nxt_hold = wake_busy;
    nxt_misc = {choices_ff[PUMP_SEL_BIT],            // R15
                choices_ff[PUMP_SEL_BIT],            // R14
                choices_ff[CONV_PU_BIT],
                choices_ff[IRQ_EDGE_BIT],
                choices_ff[CLK_MON_BIT],
                !setup_ff[WDOG_OFF_BIT],             // R3
                2'b00};
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_ff    <= RST_SETUP;
      place_ff    <= RST_PLACEMENT;
      choices_ff  <= RST_CHOICES;
      place_wr_ff <= 1'b0;
      opt_wr_ff   <= 1'b0;
      latch_ff    <= 1'b0;
      vpp_ff      <= 1'b0;
      prom_ff     <= '0;
      prdata_ff   <= 32'h00000000;
      pready_ff   <= 1'b0;
      pslverr_ff  <= 1'b0;
      map_ff      <= '0;
      rd_block_ff <= 1'b0;
      hold_ff     <= 1'b0;
      tick_ff     <= 1'b0;
      misc_ff     <= 8'h00;
    end else begin
      setup_ff    <= nxt_setup;
      place_ff    <= nxt_place;
      choices_ff  <= nxt_choices;
      place_wr_ff <= nxt_place_wr;
      opt_wr_ff   <= nxt_opt_wr;
      latch_ff    <= nxt_latch;
      vpp_ff      <= nxt_vpp;
      prom_ff     <= nxt_prom;
      prdata_ff   <= nxt_prdata;
      pready_ff   <= nxt_pready;
      pslverr_ff  <= nxt_pslverr;
      map_ff      <= nxt_map;
      rd_block_ff <= nxt_rd_block;
      hold_ff     <= nxt_hold;
      tick_ff     <= tick_raw;
      misc_ff     <= nxt_misc;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata          = prdata_ff;
  assign pready          = pready_ff;
  assign pslverr         = pslverr_ff;
  assign map_sel         = map_ff;
  assign prom_read_block = rd_block_ff;
  assign prom_latch      = prom_ff;
  assign prom_vpp        = vpp_ff;
  assign cpu_hold        = hold_ff;
  assign wdog_tick       = tick_ff;
  assign pump_rc_sel     = misc_ff[7];
  assign conv_rc_sel     = misc_ff[6];
  assign conv_power_up   = misc_ff[5];
  assign irq_edge_only   = misc_ff[4];
  assign clk_monitor_en  = misc_ff[3];
  assign wdog_enabled    = misc_ff[2];
endmodule // mmc_top
`default_nettype wire

/* tb/mmc_assertions.sv */
/*
  Concurrent checks on the ports of mmc_top.
  Assumes one pclk domain and presetn as its reset.
*/
`timescale 1ns/1ps
`default_nettype none
module mmc_assertions
  import mmc_pkg::*;
#(
  parameter logic [15:0] ROM_BASE = 16'hd000
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 special_mode,
  input wire logic                 single_chip,
  input wire logic                 cpu_valid,
  input wire logic [15:0]          cpu_addr,
  input wire logic [7:0]           prom_cell_rdata,
  input wire logic                 stop_wake,
  input wire mmc_pkg::mmc_map_type map_sel,
  input wire logic                 prom_read_block,
  input wire mmc_pkg::mmc_prom_type prom_latch,
  input wire logic                 prom_vpp,
  input wire logic                 cpu_hold,
  input wire logic                 wdog_tick,
  input wire logic                 wdog_enabled,
  input wire logic                 pump_rc_sel,
  input wire logic                 conv_rc_sel,
  input wire logic                 irq_edge_only
);
  // ----------------------------------------------------------------
  // Helper counters and checks
  // ----------------------------------------------------------------
  logic [12:0] hold_ff;
  logic [6:0]  win_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ff <= 13'h0;
      win_ff  <= 7'h0;
    end else begin
      hold_ff <= cpu_hold ? hold_ff + 13'h1 : 13'h0;
      win_ff  <= win_ff + {6'h0, win_ff != 7'h7f};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_rom_forced: assert property (cpu_valid && single_chip && cpu_addr >= ROM_BASE
    |=> !map_sel.ext) else $error("rom range decoded external");
  a_map_onehot: assert property (cpu_valid |=> $onehot(map_sel))
    else $error("decode not one region");
  a_wdog_quiet: assert property (!wdog_enabled && !$past(wdog_enabled) |-> !wdog_tick)
    else $error("tick while watchdog off");
  a_pump_conv: assert property (pump_rc_sel == conv_rc_sel)
    else $error("pump and converter clocks differ");
  a_wake_start: assert property ($rose(stop_wake) |-> ##[1:3] cpu_hold)
    else $error("hold missing after wake");
  a_wake_len: assert property ($fell(cpu_hold) |-> hold_ff == 13'd4 || hold_ff == 13'd4000)
    else $error("hold length wrong");
  a_vpp_latch: assert property ($rose(prom_vpp) |-> prom_read_block)
    else $error("voltage without latch");
  a_capture_latch: assert property ($changed(prom_latch) |-> $past(prom_read_block))
    else $error("capture without latch");
  a_only_clears: assert property ($changed(prom_latch)
    |-> (prom_latch.data & ~$past(prom_cell_rdata)) == 8'h00) else $error("zero turned to one");
  a_opt_locked: assert property ($changed(irq_edge_only) |-> special_mode || win_ff < 7'd66)
    else $error("option changed after window");
endmodule // mmc_assertions

bind mmc_top mmc_assertions #(.ROM_BASE(ROM_BASE)) i_mmc_assertions (
  .pclk, .presetn, .special_mode, .single_chip, .cpu_valid, .cpu_addr,
  .prom_cell_rdata, .stop_wake, .map_sel, .prom_read_block, .prom_latch,
  .prom_vpp, .cpu_hold, .wdog_tick, .wdog_enabled, .pump_rc_sel,
  .conv_rc_sel, .irq_edge_only
);
`default_nettype wire

/* tb/mmc_cpu_model.sv */
/*
  CPU bus side: one-cycle accesses and the addressed PROM cell.
  Assumes pclk is the E clock.
*/
`timescale 1ns/1ps
`default_nettype none
module mmc_cpu_model (
  input  wire logic        pclk,
  output var  logic        cpu_valid,
  output var  logic        cpu_write,
  output var  logic [15:0] cpu_addr,
  output var  logic [7:0]  cpu_wdata,
  output var  logic [7:0]  prom_cell_rdata
);
  // Partly programmed cell, erased bits read 1
  assign prom_cell_rdata = 8'hf0;
  initial begin
    cpu_valid = 1'b0;
    cpu_write = 1'b0;
    cpu_addr  = 16'h0;
    cpu_wdata = 8'h0;
  end
  // One access, then address and data stop showing old values
  task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(posedge pclk);
    cpu_valid <= 1'b1;
    cpu_write <= w;
    cpu_addr  <= a;
    cpu_wdata <= d;
    @(posedge pclk);
    cpu_valid <= 1'b0;
    cpu_write <= 1'b0;
    cpu_addr  <= ~a;
    cpu_wdata <= ~d;
  endtask
endmodule // mmc_cpu_model
`default_nettype wire

/* tb/tb.sv */
/*
  Self-checking bench for mmc_top over APB and the CPU bus.
  Assumes the default parameters of mmc_top.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mmc_pkg::*;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic         special_mode, single_chip, stop_wake, cpu_valid, cpu_write;
  logic [7:0]   paddr, cpu_wdata, prom_cell_rdata;
  logic [15:0]  cpu_addr;
  logic [31:0]  pwdata, prdata, rd;
  mmc_map_type  map_sel;
  mmc_prom_type prom_latch;
  logic         prom_read_block, prom_vpp, cpu_hold, wdog_tick, wdog_enabled;
  logic         pump_rc_sel, conv_rc_sel, conv_power_up, irq_edge_only, clk_monitor_en;
  int           bad_count, cmp_count;
  logic [15:0]  row_addr [8] = '{16'h0010, 16'h00ff, 16'h0100, 16'h1000,
                                 16'h103f, 16'h1040, 16'hf800, 16'hd000};
  logic [4:0]   row_map  [8] = '{5'h08, 5'h08, 5'h01, 5'h10, 5'h10, 5'h01, 5'h04, 5'h02};

  mmc_top i_mmc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .special_mode, .single_chip, .cpu_valid, .cpu_write,
    .cpu_addr, .cpu_wdata, .prom_cell_rdata, .stop_wake, .map_sel, .prom_read_block,
    .prom_latch, .prom_vpp, .cpu_hold, .wdog_tick, .wdog_enabled, .pump_rc_sel,
    .conv_rc_sel, .conv_power_up, .irq_edge_only, .clk_monitor_en);
  mmc_cpu_model i_mmc_cpu_model (.pclk, .cpu_valid, .cpu_write, .cpu_addr,
    .cpu_wdata, .prom_cell_rdata);

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic conclude();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer; only the 1 ms time limit ends a hung access
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wrt(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic dec(input logic [15:0] a, input logic [4:0] e);
    i_mmc_cpu_model.acc(a, 1'b0, 8'h00);
    #1 chk(32'(map_sel), 32'(e));
  endtask
  task automatic wake(input int e);
    int n;
    int h;
    @(posedge pclk) stop_wake <= 1'b1;
    @(posedge pclk) stop_wake <= 1'b0;
    n = 0;
    h = 0;
    while (n < 5000 && !(h > 0 && cpu_hold !== 1'b1)) begin
      @(posedge pclk);
      n++;
      if (cpu_hold === 1'b1) h++;
    end
    chk(h, e);
  endtask
  task automatic wdp(input int e);
    int n;
    n = 0;
    do begin @(posedge pclk); n++; end while (wdog_tick !== 1'b1 && n < 70000);
    n = 0;
    do begin @(posedge pclk); n++; end while (wdog_tick !== 1'b1 && n < 70000);
    chk(n, e);
  endtask

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #1000000;
    bad_count++;
    conclude();
  end
  initial begin
    {presetn, psel, penable, pwrite, special_mode, single_chip, stop_wake} = 7'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    bad_count = 0;
    cmp_count = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) dec(row_addr[i], row_map[i]);
    rdc(OFS_SETUP, 32'hff);
    rdc(OFS_PLACEMENT, 32'h01);
    rdc(OFS_CHOICES, 32'h10);
    wrt(OFS_PLACEMENT, 32'h23);
    wrt(OFS_PLACEMENT, 32'h45);
    rdc(OFS_PLACEMENT, 32'h23);
    wrt(OFS_CHOICES, 32'hf4);
    rdc(OFS_CHOICES, 32'hf0);
    chk(32'({pump_rc_sel, conv_rc_sel, conv_power_up, irq_edge_only}), 32'hf);
    wrt(OFS_CHOICES, 32'h0b);
    rdc(OFS_CHOICES, 32'h38);
    chk(32'({pump_rc_sel, clk_monitor_en, irq_edge_only}), 32'h3);
    dec(16'h2010, 5'h08);
    dec(16'h3010, 5'h10);
    wrt(OFS_SETUP, 32'h50);
    rdc(OFS_SETUP, 32'h58);
    dec(16'hd000, 5'h01);
    dec(16'h5800, 5'h01);
    chk(32'(wdog_enabled), 32'h1);
    @(posedge pclk) single_chip <= 1'b1;
    dec(16'hd000, 5'h02);
    @(posedge pclk) single_chip <= 1'b0;
    wrt(OFS_SETUP, 32'h53);
    dec(16'h5800, 5'h04);
    dec(16'h57ff, 5'h01);
    wake(4000);
    wdp(32768);
    @(posedge pclk) special_mode <= 1'b1;
    wrt(OFS_CHOICES, 32'h00);
    rdc(OFS_CHOICES, 32'h00);
    wake(4);
    @(posedge pclk) special_mode <= 1'b0;
    wrt(OFS_PROM_CTRL, 32'h21);
    rdc(OFS_PROM_CTRL, 32'h20);
    chk(32'(prom_read_block), 32'h1);
    i_mmc_cpu_model.acc(16'hd010, 1'b1, 8'h5a);
    #1 chk(32'(prom_latch), 32'hd01050);
    wrt(OFS_PROM_CTRL, 32'h21);
    rdc(OFS_PROM_CTRL, 32'h21);
    chk(32'(prom_vpp), 32'h1);
    wrt(OFS_PROM_CTRL, 32'h01);
    rdc(OFS_PROM_CTRL, 32'h21);
    wrt(OFS_PROM_CTRL, 32'h00);
    rdc(OFS_PROM_CTRL, 32'h20);
    wrt(OFS_PROM_CTRL, 32'h00);
    rdc(OFS_PROM_CTRL, 32'h00);
    rdc(8'h14, 32'h0);
    chk(32'(perr), 32'h1);
    @(posedge pclk) presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (70) @(posedge pclk);
    wrt(OFS_PLACEMENT, 32'h45);
    rdc(OFS_PLACEMENT, 32'h01);
    wrt(OFS_CHOICES, 32'h33);
    rdc(OFS_CHOICES, 32'h10);
    conclude();
  end
endmodule // tb
`default_nettype wire
